// ==== rtl/phy_basic_control.v ====
// Management control register of a 10/100 PHY with its serial slave.
// Assumes mdc, mdio and MII transmit pins are asynchronous to sys_clk,
// which must run well above four times the management clock.
`include "phy_ctl_defines.vh"
`timescale 1ns/10ps
`default_nettype none

module phy_basic_control #(
    parameter RESET_CYCLES = `SOFT_RESET_CYCLES,
    parameter DEAD_CYCLES = `DEAD_CYCLES,
    parameter SUPPORT_HALF = 1,
    parameter SUPPORT_FULL = 1
) (
    // Clock and reset
    input wire sys_clk,
    input wire sys_rst,
    // Management pins
    input wire mdc,
    input wire mdio_in,
    output reg mdio_out,
    output reg mdio_oe_n,
    input wire [4:0] phy_addr,
    // Configuration pins
    input wire lb_cfg_en,
    input wire lb_cfg_val,
    input wire spd_cfg_en,
    input wire spd_cfg_val,
    // Negotiation engine
    input wire an_speed_100,
    input wire an_full_duplex,
    output reg an_enable,
    output reg an_restart,
    // PHY mode outputs
    output reg speed_100,
    output reg full_duplex,
    output reg loopback_en,
    output reg power_down,
    output reg isolate,
    output reg mii_oe_n,
    // MII data
    input wire [3:0] txd,
    input wire tx_en,
    input wire [3:0] line_rxd,
    input wire line_rx_dv,
    output reg [3:0] rxd,
    output reg rx_dv,
    output reg col
);

    localparam S_IDLE = 3'h0;
    localparam S_HDR = 3'h1;
    localparam S_TA = 3'h2;
    localparam S_RDATA = 3'h3;
    localparam S_WDATA = 3'h4;

    // Sized copies of the constants, cut on purpose to the counter widths where they are loaded
    localparam [15:0] CTL_DEF = `CTL_DEFAULT;
    localparam [31:0] RST_LOAD_W = RESET_CYCLES - 1;
    localparam [31:0] DEAD_LOAD_W = DEAD_CYCLES;

    // Pin override: configuration pin wins when enabled
    function pin_pick;
        input en;
        input val;
        input bitv;
        begin
            pin_pick = en ? val : bitv;
        end
    endfunction

    // ----------------------------------------------------------------
    // Synchronisers
    // ----------------------------------------------------------------
    reg [2:0] mdc_sync_q;
    reg [1:0] mdio_sync_q;
    reg [1:0] lbe_sync_q, lbv_sync_q, spe_sync_q, spv_sync_q;
    reg [3:0] txd_s1_q, txd_s2_q;
    reg [1:0] txen_sync_q;
    wire mdc_rise;
    wire mdio_bit;
    wire lb_eff;
    wire spd_eff;

    // Two flops per asynchronous input, third mdc flop for edge finding
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mdc_sync_q <= 3'h7; // Idle level of mdc, no false rise after reset
            mdio_sync_q <= 2'h3;
            lbe_sync_q <= 2'h0;
            lbv_sync_q <= 2'h0;
            spe_sync_q <= 2'h0;
            spv_sync_q <= 2'h0;
            txd_s1_q <= 4'h0;
            txd_s2_q <= 4'h0;
            txen_sync_q <= 2'h0;
        end else begin
            mdc_sync_q <= {mdc_sync_q[1:0], mdc};
            mdio_sync_q <= {mdio_sync_q[0], mdio_in};
            lbe_sync_q <= {lbe_sync_q[0], lb_cfg_en};
            lbv_sync_q <= {lbv_sync_q[0], lb_cfg_val};
            spe_sync_q <= {spe_sync_q[0], spd_cfg_en};
            spv_sync_q <= {spv_sync_q[0], spd_cfg_val};
            txd_s1_q <= txd;
            txd_s2_q <= txd_s1_q;
            txen_sync_q <= {txen_sync_q[0], tx_en};
        end
    end

    // Sample on the rising management clock edge
    assign mdc_rise = mdc_sync_q[1] & ~mdc_sync_q[2];
    assign mdio_bit = mdio_sync_q[1];

    // ----------------------------------------------------------------
    // Control register state
    // ----------------------------------------------------------------
    reg rst_busy_q, rst_busy_d;
    reg [7:0] rst_cnt_q, rst_cnt_d;
    reg lb_q, lb_d;
    reg spd_q, spd_d;
    reg ane_q, ane_d;
    reg pd_q, pd_d;
    reg iso_q, iso_d;
    reg dup_q, dup_d;
    reg colt_q, colt_d;
    reg restart_q, restart_d;
    wire [15:0] rd_word;
    wire dup_fixed;

    // Single-mode parts pin the duplex bit to the supported mode
    assign dup_fixed = (SUPPORT_FULL == 0) ? 1'b0 :
                       (SUPPORT_HALF == 0) ? 1'b1 : dup_q;
    assign lb_eff = pin_pick(lbe_sync_q[1], lbv_sync_q[1], lb_q);
    assign spd_eff = pin_pick(spe_sync_q[1], spv_sync_q[1], spd_q);

    // Read image; restart always reads zero, reserved bits zero
    assign rd_word = {rst_busy_q, lb_eff, spd_eff, ane_q, pd_q, iso_q,
                      1'b0, dup_fixed, colt_q, 7'h00};

    // ----------------------------------------------------------------
    // Management frame engine
    // ----------------------------------------------------------------
    reg [2:0] st_q, st_d;
    reg [5:0] pre_q, pre_d;
    reg [3:0] cnt_q, cnt_d;
    reg [15:0] sh_q, sh_d;
    reg rd_q, rd_d;
    reg hit_reg_q, hit_reg_d;
    reg mdo_d, mdoe_n_d;
    reg wr_go;
    reg [15:0] wr_val;
    reg [12:0] hdr;

    // Frame sequencing on rising mdc edges
    always @* begin
        st_d = st_q;
        pre_d = pre_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        rd_d = rd_q;
        hit_reg_d = hit_reg_q;
        mdo_d = mdio_out;
        mdoe_n_d = mdio_oe_n;
        wr_go = 1'b0;
        wr_val = {sh_q[14:0], mdio_bit};
        hdr = {sh_q[11:0], mdio_bit};
        if (mdc_rise) begin
            case (st_q)
                S_IDLE: begin
                    // Count preamble ones, a zero after 32 opens the frame
                    if (mdio_bit) begin
                        if (pre_q != `MG_PREAMBLE_BITS)
                            pre_d = pre_q + 6'h01;
                    end else begin
                        pre_d = 6'h00;
                        if (pre_q == `MG_PREAMBLE_BITS) begin
                            st_d = S_HDR;
                            cnt_d = 4'h0;
                        end
                    end
                end
                S_HDR: begin
                    sh_d = {sh_q[14:0], mdio_bit};
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q == `MG_HDR_LAST) begin
                        cnt_d = 4'h0;
                        rd_d = (hdr[11:10] == `MG_OP_READ);
                        hit_reg_d = (hdr[4:0] == `REG_BASIC_CONTROL);
                        // Start second bit, opcode and our address must match
                        if (hdr[12] && hdr[9:5] == phy_addr &&
                            (hdr[11:10] == `MG_OP_READ ||
                             hdr[11:10] == `MG_OP_WRITE))
                            st_d = S_TA;
                        else
                            st_d = S_IDLE;
                    end
                end
                S_TA: begin
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q == 4'h0) begin
                        // First turnaround bit left alone, drive zero next
                        if (rd_q && hit_reg_q) begin
                            mdoe_n_d = 1'b0;
                            mdo_d = 1'b0;
                        end
                    end else begin
                        cnt_d = 4'h0;
                        st_d = rd_q ? S_RDATA : S_WDATA;
                        sh_d = {rd_word[14:0], 1'b0};
                        if (rd_q && hit_reg_q)
                            mdo_d = rd_word[15];
                    end
                end
                S_RDATA: begin
                    cnt_d = cnt_q + 4'h1;
                    mdo_d = sh_q[15];
                    sh_d = {sh_q[14:0], 1'b0};
                    if (cnt_q == `MG_DATA_LAST) begin
                        mdoe_n_d = 1'b1;
                        mdo_d = 1'b1;
                        st_d = S_IDLE;
                    end
                end
                S_WDATA: begin
                    cnt_d = cnt_q + 4'h1;
                    sh_d = wr_val;
                    if (cnt_q == `MG_DATA_LAST) begin
                        wr_go = hit_reg_q;
                        st_d = S_IDLE;
                    end
                end
                default: begin
                    st_d = S_IDLE;
                end
            endcase
        end
    end

    // Register updates, soft reset sequencing and self-clearing bits
    always @* begin
        rst_busy_d = rst_busy_q;
        rst_cnt_d = rst_cnt_q;
        lb_d = lb_q;
        spd_d = spd_q;
        ane_d = ane_q;
        pd_d = pd_q;
        iso_d = iso_q;
        dup_d = dup_q;
        colt_d = colt_q;
        restart_d = 1'b0;
        if (rst_busy_q) begin
            if (rst_cnt_q == 8'h00) begin
                // Defaults restored as the busy bit drops
                rst_busy_d = 1'b0;
                lb_d = CTL_DEF[`BIT_LOOPBACK];
                spd_d = CTL_DEF[`BIT_SPEED];
                ane_d = CTL_DEF[`BIT_AN_ENABLE];
                pd_d = CTL_DEF[`BIT_POWER_DOWN];
                iso_d = CTL_DEF[`BIT_ISOLATE];
                dup_d = CTL_DEF[`BIT_DUPLEX];
                colt_d = CTL_DEF[`BIT_COL_TEST];
            end else begin
                rst_cnt_d = rst_cnt_q - 8'h01;
            end
        end else if (wr_go) begin
            // Writes are refused while the reset runs
            if (wr_val[`BIT_SOFT_RESET]) begin
                rst_busy_d = 1'b1;
                rst_cnt_d = RST_LOAD_W[7:0];
            end else begin
                lb_d = wr_val[`BIT_LOOPBACK];
                spd_d = wr_val[`BIT_SPEED];
                ane_d = wr_val[`BIT_AN_ENABLE];
                pd_d = wr_val[`BIT_POWER_DOWN];
                iso_d = wr_val[`BIT_ISOLATE];
                dup_d = wr_val[`BIT_DUPLEX];
                colt_d = wr_val[`BIT_COL_TEST];
                restart_d = wr_val[`BIT_AN_RESTART];
            end
        end
    end

    // ----------------------------------------------------------------
    // State flops
    // ----------------------------------------------------------------
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= S_IDLE;
            pre_q <= 6'h00;
            cnt_q <= 4'h0;
            sh_q <= 16'h0000;
            rd_q <= 1'b0;
            hit_reg_q <= 1'b0;
            mdio_out <= 1'b1;
            mdio_oe_n <= 1'b1;
            rst_busy_q <= 1'b0;
            rst_cnt_q <= 8'h00;
            lb_q <= 1'b0;
            spd_q <= 1'b1;
            ane_q <= 1'b1;
            pd_q <= 1'b0;
            iso_q <= 1'b0;
            dup_q <= 1'b0;
            colt_q <= 1'b0;
            restart_q <= 1'b0;
        end else begin
            st_q <= st_d;
            pre_q <= pre_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            rd_q <= rd_d;
            hit_reg_q <= hit_reg_d;
            mdio_out <= mdo_d;
            mdio_oe_n <= mdoe_n_d;
            rst_busy_q <= rst_busy_d;
            rst_cnt_q <= rst_cnt_d;
            lb_q <= lb_d;
            spd_q <= spd_d;
            ane_q <= ane_d;
            pd_q <= pd_d;
            iso_q <= iso_d;
            dup_q <= dup_d;
            colt_q <= colt_d;
            restart_q <= restart_d;
        end
    end

    // ----------------------------------------------------------------
    // Mode outputs and loopback datapath
    // ----------------------------------------------------------------
    reg lb_prev_q;
    reg [7:0] dead_q;
    wire tx_en_eff;

    assign tx_en_eff = txen_sync_q[1] & ~iso_q;

    // Output flops: forced settings apply only without negotiation
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            an_enable <= 1'b1;
            an_restart <= 1'b0;
            speed_100 <= 1'b1;
            full_duplex <= 1'b0;
            loopback_en <= 1'b0;
            power_down <= 1'b0;
            isolate <= 1'b0;
            mii_oe_n <= 1'b0;
            lb_prev_q <= 1'b0;
            dead_q <= 8'h00;
            rxd <= 4'h0;
            rx_dv <= 1'b0;
            col <= 1'b0;
        end else begin
            an_enable <= ane_q;
            an_restart <= restart_q;
            speed_100 <= ane_q ? an_speed_100 : spd_eff;
            full_duplex <= lb_eff ? 1'b0 :
                           (ane_q ? an_full_duplex : dup_fixed);
            loopback_en <= lb_eff;
            power_down <= pd_q;
            isolate <= iso_q;
            mii_oe_n <= iso_q;
            lb_prev_q <= lb_eff;
            // Receive blanking after entering loopback
            if (lb_eff && !lb_prev_q)
                dead_q <= DEAD_LOAD_W[7:0];
            else if (dead_q != 8'h00)
                dead_q <= dead_q - 8'h01;
            // Loopback takes the transmit nibble, line input is cut off
            if (lb_eff) begin
                rxd <= txd_s2_q;
                rx_dv <= tx_en_eff && (dead_q == 8'h00);
            end else begin
                rxd <= line_rxd;
                rx_dv <= line_rx_dv;
            end
            col <= colt_q & tx_en_eff;
        end
    end

endmodule

`default_nettype wire

// ==== rtl/phy_ctl_defines.vh ====
// Constants for the management control register block.
// Assumes inclusion by bare name from the rtl folder.
`ifndef PHY_CTL_DEFINES_VH
`define PHY_CTL_DEFINES_VH

// ----------------------------------------------------------------
// Register map and fields
// ----------------------------------------------------------------
`define REG_BASIC_CONTROL 5'h00
`define BIT_SOFT_RESET 15
`define BIT_LOOPBACK 14
`define BIT_SPEED 13
`define BIT_AN_ENABLE 12
`define BIT_POWER_DOWN 11
`define BIT_ISOLATE 10
`define BIT_AN_RESTART 9
`define BIT_DUPLEX 8
`define BIT_COL_TEST 7
`define CTL_DEFAULT 16'h3000

// ----------------------------------------------------------------
// Management frame
// ----------------------------------------------------------------
`define MG_PREAMBLE_BITS 6'h20
`define MG_HDR_LAST 4'hC
`define MG_DATA_LAST 4'hF
`define MG_OP_READ 2'h2
`define MG_OP_WRITE 2'h1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_PS 5000
`define DEAD_TIME_PS 560000
`define DEAD_CYCLES (`DEAD_TIME_PS / `CLK_PERIOD_PS)
`define SOFT_RESET_CYCLES 64

`endif

// ==== sim/mdio_manager.sv ====
// Management manager model that frames register accesses on mdc and mdio.
// Assumes the bench resolves the shared data line with a pull-up.
`timescale 1ns/10ps
`default_nettype none
module mdio_manager (
    // Management pins
    output logic mdc,
    output logic mgr_out,
    output logic mgr_oe,
    input wire logic mdio_wire
);
    logic ta_bit;

    // Idle: clock stands high, line released
    initial begin
        mdc = 1'b1;
        mgr_out = 1'b1;
        mgr_oe = 1'b0;
        ta_bit = 1'b1;
    end

    // One bit: drive after the fall, sample just before the rise
    task automatic bit_cyc(input logic drv, input logic val, output logic smp);
        mdc = 1'b0;
        mgr_oe = drv;
        mgr_out = val;
        #40;
        smp = mdio_wire;
        mdc = 1'b1;
        #40;
    endtask

    // Whole frame, read data returned in rd
    task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
        input logic [15:0] wd, output logic [15:0] rd);
        logic [13:0] hdr;
        logic s;
        int i;
        hdr = {2'b01, op, pa, ra};
        rd = 16'h0000;
        #7;
        for (i = 0; i < 32; i++) bit_cyc(1'b1, 1'b1, s);
        for (i = 13; i >= 0; i--) bit_cyc(1'b1, hdr[i], s);
        bit_cyc(op == 2'b01, 1'b1, s);
        bit_cyc(op == 2'b01, 1'b0, s);
        ta_bit = s;
        for (i = 15; i >= 0; i--) begin
            bit_cyc(op == 2'b01, wd[i], s);
            rd[i] = s;
        end
        mgr_oe = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== sim/phy_basic_control_bench.sv ====
// Self-checking bench for the management control register block.
// Assumes the manager model and the bound checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
module phy_basic_control_bench;
    logic sys_clk, sys_rst, mdc, mgr_out, mgr_oe, mdio_wire, mdio_out, mdio_oe_n;
    logic lb_cfg_en, lb_cfg_val, spd_cfg_en, spd_cfg_val, an_speed_100, an_full_duplex;
    logic an_enable, an_restart, speed_100, full_duplex, loopback_en, power_down;
    logic isolate, mii_oe_n, tx_en, line_rx_dv, rx_dv, col;
    logic [3:0] txd, line_rxd, rxd;
    logic [15:0] rdat;
    int err_count, comparisons, restarts, r0, i;

    // Shared data line with pull-up
    assign mdio_wire = !mdio_oe_n ? mdio_out : (mgr_oe ? mgr_out : 1'b1);

    phy_basic_control i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .mdc(mdc),
        .mdio_in(mdio_wire), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .phy_addr(5'h05),
        .lb_cfg_en(lb_cfg_en), .lb_cfg_val(lb_cfg_val), .spd_cfg_en(spd_cfg_en),
        .spd_cfg_val(spd_cfg_val), .an_speed_100(an_speed_100),
        .an_full_duplex(an_full_duplex), .an_enable(an_enable), .an_restart(an_restart),
        .speed_100(speed_100), .full_duplex(full_duplex), .loopback_en(loopback_en),
        .power_down(power_down), .isolate(isolate), .mii_oe_n(mii_oe_n), .txd(txd),
        .tx_en(tx_en), .line_rxd(line_rxd), .line_rx_dv(line_rx_dv), .rxd(rxd),
        .rx_dv(rx_dv), .col(col));

    mdio_manager i_mgr (.mdc(mdc), .mgr_out(mgr_out), .mgr_oe(mgr_oe), .mdio_wire(mdio_wire));

    // Clock
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Restart pulse counter
    always @(posedge sys_clk) begin
        if (an_restart === 1'b1) restarts <= restarts + 1;
    end

    // Compare, access and closing tasks
    task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: register %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: pin %b, wanted %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] d);
        @(negedge sys_clk);
        i_mgr.xfer(2'b01, 5'h05, 5'h00, d, rdat);
        repeat (6) @(negedge sys_clk);
    endtask
    task automatic rd(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] exp);
        @(negedge sys_clk);
        i_mgr.xfer(2'b10, pa, ra, 16'h0000, rdat);
        chk_reg(rdat, exp);
    endtask
    task automatic end_sim;
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Watchdog
    initial begin
        #450000;
        err_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        end_sim();
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        {sys_rst, an_speed_100, line_rx_dv} = 3'b111;
        {lb_cfg_en, lb_cfg_val, spd_cfg_en, spd_cfg_val, an_full_duplex, tx_en} = 6'h00;
        {txd, line_rxd} = 8'h03;
        {err_count, comparisons, restarts} = 0;
        repeat (6) @(negedge sys_clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        rd(5'h05, 5'h00, 16'h3000);
        chk_pin(i_mgr.ta_bit, 1'b0);
        chk_pin(speed_100, 1'b1);
        wr(16'h0000);
        rd(5'h05, 5'h00, 16'h0000);
        chk_pin(an_enable, 1'b0);
        chk_pin(speed_100, 1'b0);
        chk_pin(full_duplex, 1'b0);
        wr(16'h2100);
        chk_pin(speed_100, 1'b1);
        chk_pin(full_duplex, 1'b1);
        {an_speed_100, an_full_duplex} = 2'b01;
        wr(16'h1000);
        chk_pin(speed_100, 1'b0);
        chk_pin(full_duplex, 1'b1);
        r0 = restarts;
        wr(16'h1200);
        chk_pin(restarts == r0 + 1, 1'b1);
        rd(5'h05, 5'h00, 16'h1000);
        wr(16'h1000);
        chk_pin(restarts == r0 + 1, 1'b1);
        wr(16'h0800);
        chk_pin(power_down, 1'b1);
        tx_en = 1'b1;
        wr(16'h0480);
        chk_pin(mii_oe_n, 1'b1);
        chk_pin(col, 1'b0);
        rd(5'h05, 5'h00, 16'h0480);
        wr(16'h0080);
        chk_pin(col, 1'b1);
        chk_pin(power_down, 1'b0);
        tx_en = 1'b0;
        repeat (6) @(negedge sys_clk);
        chk_pin(col, 1'b0);
        {txd, tx_en} = 5'h15;
        wr(16'h4100);
        chk_pin(rx_dv, 1'b0);
        chk_pin(full_duplex, 1'b0);
        repeat (120) @(negedge sys_clk);
        chk_pin(rx_dv, 1'b1);
        chk_reg({12'h000, rxd}, 16'h000A);
        {tx_en, lb_cfg_en, lb_cfg_val} = 3'b010;
        repeat (6) @(negedge sys_clk);
        chk_pin(loopback_en, 1'b0);
        rd(5'h05, 5'h00, 16'h0100);
        {spd_cfg_en, spd_cfg_val} = 2'b10;
        wr(16'h2000);
        rd(5'h05, 5'h00, 16'h0000);
        chk_pin(speed_100, 1'b0);
        {lb_cfg_en, spd_cfg_en} = 2'b00;
        rd(5'h05, 5'h03, 16'hFFFF);
        rd(5'h06, 5'h00, 16'hFFFF);
        wr(16'h0980);
        wr(16'h8000);
        i = 0;
        do begin
            @(negedge sys_clk);
            i_mgr.xfer(2'b10, 5'h05, 5'h00, 16'h0000, rdat);
            i++;
        end while (rdat[15] !== 1'b0 && i < 4);
        chk_reg(rdat, 16'h3000);
        chk_pin(power_down, 1'b0);
        chk_pin(an_enable, 1'b1);
        end_sim();
    end
endmodule
`default_nettype wire

// ==== sim/phy_ctl_checker.sv ====
// Port checker for the management control register block.
// Assumes it is bound to the block and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module phy_ctl_checker (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Management pins
    input wire logic mdio_out,
    input wire logic mdio_oe_n,
    // Negotiation and mode
    input wire logic an_speed_100,
    input wire logic an_full_duplex,
    input wire logic an_enable,
    input wire logic an_restart,
    input wire logic speed_100,
    input wire logic full_duplex,
    input wire logic loopback_en,
    input wire logic isolate,
    input wire logic mii_oe_n,
    // MII outputs
    input wire logic rx_dv,
    input wire logic col
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // Mode outputs against their causes
    iso_outputs_a: assert property (mii_oe_n == isolate)
        else $error("MII enable does not follow isolate");
    iso_no_col_a: assert property (isolate |-> !col)
        else $error("collision shown while isolated");
    lb_duplex_a: assert property (loopback_en |-> !full_duplex)
        else $error("full duplex shown in loopback");
    an_speed_a: assert property ($past(an_enable) && an_enable |-> speed_100 == $past(an_speed_100))
        else $error("speed does not follow negotiation");
    an_duplex_a: assert property ($past(an_enable) && an_enable && !loopback_en &&
        !$past(loopback_en) |-> full_duplex == $past(an_full_duplex))
        else $error("duplex does not follow negotiation");
    restart_pulse_a: assert property (an_restart |=> !an_restart)
        else $error("restart pulse too long");
    dead_time_a: assert property ($rose(loopback_en) |=> !rx_dv [*8])
        else $error("receive valid during loopback dead time");

    // Read turnaround and data drive
    ta_zero_a: assert property ($fell(mdio_oe_n) |-> !mdio_out)
        else $error("turnaround bit not driven low");
    read_hold_a: assert property ($fell(mdio_oe_n) |=> !mdio_oe_n [*8])
        else $error("read drive released early");

    // Main scenarios
    cover property ($rose(loopback_en));
    cover property (an_restart);
    cover property ($fell(mdio_oe_n));
endmodule

bind phy_basic_control phy_ctl_checker i_chk (.sys_clk, .sys_rst, .mdio_out, .mdio_oe_n,
    .an_speed_100, .an_full_duplex, .an_enable, .an_restart, .speed_100, .full_duplex,
    .loopback_en, .isolate, .mii_oe_n, .rx_dv, .col);
`default_nettype wire
